// File: logic/tcrf_cfg.svh
`ifndef TCRF_CFG_SVH
`define TCRF_CFG_SVH
// Word addresses on the register port.
`define TCRF_ADDR_RES_LAST  4'h7
`define TCRF_ADDR_CONFIG    4'h8
`define TCRF_ADDR_BURNOUT   4'h9
`define TCRF_ADDR_INT_STAT  4'ha
`define TCRF_ADDR_INT_MASK  4'hb
// Configuration register field positions.
`define TCRF_CFG_DET_OFF    0
`define TCRF_CFG_TWOS       1
`define TCRF_CFG_DOWN       2
`define TCRF_CFG_RESET      3'h0
// Result encodings.
`define TCRF_UNI_TOP        16'hffff
`define TCRF_BIP_TOP        16'h7fff
`define TCRF_SCALE_BOTTOM   16'h0000
`define TCRF_SIGN_BIT       15
`define TCRF_ZERO_WORD      16'h0000
// Interrupt status layout: burnout events low, conversion done high.
`define TCRF_IRQ_DONE_LSB   4
`define TCRF_IRQ_RESET      8'h00
`endif

// File: logic/tcrf_pkg.sv
package tcrf_pkg;
  // Word on the host side of every channel result.
  typedef logic [15:0] tcrf_word_t;
  // Channel number, zero based.
  typedef logic [1:0]  tcrf_ch_t;
  // Register port word address.
  typedef logic [3:0]  tcrf_addr_t;
  // Source of the registered read data.
  typedef enum logic [0:0]
  {
    TCRF_RD_REG = 1'b0,
    TCRF_RD_MEM = 1'b1
  } tcrf_rdsel_t;
endpackage

// File: logic/tcrf_mem_if.sv
`timescale 1ns/1ps
// Write and read ports of the result store.
interface tcrf_mem_if;
  import tcrf_pkg::*;
  logic       wr_en;    // Write one result word.
  tcrf_ch_t   wr_idx;   // Channel written.
  tcrf_word_t wr_data;  // Encoded result.
  tcrf_ch_t   rd_idx;   // Channel read.
  tcrf_word_t rd_data;  // Registered read data.
  modport master (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
  modport store  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface

// File: logic/tcrf_mem.sv
`timescale 1ns/1ps
`include "tcrf_cfg.svh"
// Small result store, one word per channel, read data from a register.
module tcrf_mem
  import tcrf_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  tcrf_mem_if.store  mem
);
  tcrf_word_t words_r [CHANNELS];  // One result per channel.
  tcrf_word_t rd_r;                // Read data register.

  // Each channel word is its own register so reset clears them all.
  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_word
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        words_r[g] <= `TCRF_ZERO_WORD;
      end
      else if (mem.wr_en && (mem.wr_idx == tcrf_ch_t'(g)))
      begin
        words_r[g] <= mem.wr_data;
      end
    end
  end

  // Read every cycle; the caller decides whether the word is wanted.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_r <= `TCRF_ZERO_WORD;
    end
    else
    begin
      rd_r <= words_r[mem.rd_idx];
    end
  end

  assign mem.rd_data = rd_r;
endmodule

// File: logic/tcrf_top.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "tcrf_cfg.svh"
module tcrf_top
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             conv_valid,
  input  wire tcrf_pkg::tcrf_ch_t   conv_ch,
  input  wire logic             conv_bipolar,
  input  wire logic             conv_neg,
  input  wire tcrf_pkg::tcrf_word_t conv_count,
  input  wire logic             conv_open,
  input  wire tcrf_pkg::tcrf_addr_t reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata,
  output logic [3:0]            system_status_relay_bit,
  output logic                  irq
);
  import tcrf_pkg::*;

  tcrf_mem_if mem ();              // Link to the result store.
  logic [2:0] config_r;            // Detect off, format, down scale.
  logic [3:0] burnout_r;           // Per channel burnout flags.
  logic [7:0] int_stat_r;          // Sticky interrupt events.
  logic [7:0] int_mask_r;          // Interrupt enables.
  logic [15:0] reg_data_r;         // Registered non-result read data.
  tcrf_rdsel_t rdsel_r;            // Which source answers the read.
  logic       burn;                // Burnout seen on this conversion.
  tcrf_word_t enc;                 // Encoded result word.
  tcrf_word_t mag15;               // Bipolar magnitude, sign removed.
  logic [7:0] events;              // Events raised this cycle.
  logic       res_rd;              // Read of a result word pair.

  // All checks below run on the core clock and pause during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // The store sees every conversion as one write of the encoded word.
  tcrf_mem u_mem
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .mem      (mem.store)
  );

  // Burnout counts only while detection is enabled.
  assign burn = conv_open && !config_r[`TCRF_CFG_DET_OFF];
  assign mag15 = {1'b0, conv_count[14:0]};

  // Encode the result; burnout replaces the reading altogether.
  always_comb
  begin
    if (burn && config_r[`TCRF_CFG_DOWN])
    begin
      enc = `TCRF_SCALE_BOTTOM;
    end
    else if (burn)
    begin
      enc = conv_bipolar ? `TCRF_BIP_TOP : `TCRF_UNI_TOP;
    end
    else if (!conv_bipolar)
    begin
      enc = conv_count;
    end
    else if (config_r[`TCRF_CFG_TWOS])
    begin
      // A zero magnitude with the sign set stays zero here.
      enc = conv_neg ? tcrf_word_t'(-mag15) : mag15;
    end
    else
    begin
      enc = mag15;
      enc[`TCRF_SIGN_BIT] = conv_neg;
    end
  end

  // Result word and flag land on the same edge.
  assign mem.wr_en   = conv_valid;
  assign mem.wr_idx  = conv_ch;
  assign mem.wr_data = enc;
  assign mem.rd_idx  = tcrf_ch_t'(reg_addr[2:1]);

  // Burnout flags follow each conversion of their channel.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      burnout_r <= 4'h0;
    end
    else if (conv_valid)
    begin
      burnout_r[conv_ch] <= burn;
    end
  end

  assign system_status_relay_bit = burnout_r;

  // Burnout onset and conversion done per channel raise events.
  always_comb
  begin
    events = 8'h00;
    if (conv_valid)
    begin
      events[conv_ch] = burn && !burnout_r[conv_ch];
      events[`TCRF_IRQ_DONE_LSB + 32'(conv_ch)] = 1'b1;
    end
  end

  // Configuration and mask registers written by software.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      config_r   <= `TCRF_CFG_RESET;
      int_mask_r <= `TCRF_IRQ_RESET;
    end
    else if (reg_wr && reg_addr == `TCRF_ADDR_CONFIG)
    begin
      config_r <= reg_wdata[2:0];
    end
    else if (reg_wr && reg_addr == `TCRF_ADDR_INT_MASK)
    begin
      int_mask_r <= reg_wdata[7:0];
    end
  end

  // Sticky status: a new event wins over a write-one clear.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_stat_r <= `TCRF_IRQ_RESET;
    end
    else if (reg_wr && reg_addr == `TCRF_ADDR_INT_STAT)
    begin
      int_stat_r <= (int_stat_r & ~reg_wdata[7:0]) | events;
    end
    else
    begin
      int_stat_r <= int_stat_r | events;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // Result words sit at pairs; the second of a pair reads zero.
  assign res_rd = reg_addr <= `TCRF_ADDR_RES_LAST;

  // Read decode; the store answers results, this register the rest.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_data_r <= `TCRF_ZERO_WORD;
      rdsel_r    <= TCRF_RD_REG;
    end
    else if (reg_rd && res_rd && !reg_addr[0])
    begin
      reg_data_r <= `TCRF_ZERO_WORD;
      rdsel_r    <= TCRF_RD_MEM;
    end
    else if (reg_rd && res_rd)
    begin
      reg_data_r <= `TCRF_ZERO_WORD;
      rdsel_r    <= TCRF_RD_REG;
    end
    else if (reg_rd && reg_addr == `TCRF_ADDR_CONFIG)
    begin
      reg_data_r <= {13'h0000, config_r};
      rdsel_r    <= TCRF_RD_REG;
    end
    else if (reg_rd && reg_addr == `TCRF_ADDR_BURNOUT)
    begin
      reg_data_r <= {12'h000, burnout_r};
      rdsel_r    <= TCRF_RD_REG;
    end
    else if (reg_rd && reg_addr == `TCRF_ADDR_INT_STAT)
    begin
      reg_data_r <= {8'h00, int_stat_r};
      rdsel_r    <= TCRF_RD_REG;
    end
    else if (reg_rd && reg_addr == `TCRF_ADDR_INT_MASK)
    begin
      reg_data_r <= {8'h00, int_mask_r};
      rdsel_r    <= TCRF_RD_REG;
    end
    else
    begin
      // Unmapped addresses and idle cycles read as zero.
      reg_data_r <= `TCRF_ZERO_WORD;
      rdsel_r    <= TCRF_RD_REG;
    end
  end

  // Both sources are flip-flops; only the select is muxed.
  assign reg_rdata = (rdsel_r == TCRF_RD_MEM) ? mem.rd_data : reg_data_r;

  sequence s_conv_bip_sm;
    conv_valid && conv_bipolar && !burn && !config_r[`TCRF_CFG_TWOS];
  endsequence

  property p_sign_range;
    s_conv_bip_sm |-> (conv_neg ? (enc >= 16'h8000) : (enc <= 16'h7fff));
  endproperty
  a_sign_range: assert property (p_sign_range)
    else $error("Sign-magnitude word on wrong side of 8000h.");

  property p_mag_kept;
    s_conv_bip_sm |-> ((enc & 16'h7fff) == {1'b0, conv_count[14:0]});
  endproperty
  a_mag_kept: assert property (p_mag_kept)
    else $error("Masking the sign bit does not give the magnitude.");

  property p_unipolar;
    conv_valid && !conv_bipolar && !burn
      |=> u_mem.words_r[$past(conv_ch)] == $past(conv_count);
  endproperty
  a_unipolar: assert property (p_unipolar)
    else $error("Unipolar count not stored as converted.");

  property p_twos;
    conv_valid && conv_bipolar && !burn && config_r[`TCRF_CFG_TWOS]
      |-> enc == (conv_neg ? tcrf_word_t'(16'h0000 - mag15) : mag15);
  endproperty
  a_twos: assert property (p_twos)
    else $error("Two's complement result is wrong.");

  property p_flag_with_result;
    conv_valid |=> (burnout_r[$past(conv_ch)] == $past(burn))
      && (u_mem.words_r[$past(conv_ch)] == $past(enc));
  endproperty
  a_flag_with_result: assert property (p_flag_with_result)
    else $error("Burnout flag and result did not update together.");

  property p_relay;
    // The pin itself must show the flag of the channel just converted.
    conv_valid |=> system_status_relay_bit[$past(conv_ch)] == $past(burn);
  endproperty
  a_relay: assert property (p_relay)
    else $error("Relay bits do not mirror the burnout flags.");

  property p_upscale;
    conv_valid && burn && !config_r[`TCRF_CFG_DOWN]
      |-> enc == (conv_bipolar ? `TCRF_BIP_TOP : `TCRF_UNI_TOP);
  endproperty
  a_upscale: assert property (p_upscale)
    else $error("Up scale burnout value is wrong.");

  property p_det_off;
    conv_valid && config_r[`TCRF_CFG_DET_OFF]
      |=> !burnout_r[$past(conv_ch)];
  endproperty
  a_det_off: assert property (p_det_off)
    else $error("Burnout flagged while detection disabled.");

  property p_second_word;
    reg_rd && reg_addr <= `TCRF_ADDR_RES_LAST && reg_addr[0]
      |=> reg_rdata == `TCRF_ZERO_WORD;
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("Second word of a result pair is not zero.");
endmodule

// File: dv/tcrf_host.sv
`timescale 1ns/1ps
// Host controller model: one-cycle strobes, read data taken the cycle after.
module tcrf_host
(
  input  wire logic            core_clk,
  output tcrf_pkg::tcrf_addr_t reg_addr,
  output logic [15:0]          reg_wdata,
  output logic                 reg_wr,
  output logic                 reg_rd,
  input  wire logic [15:0]     reg_rdata
);
  import tcrf_pkg::*;

  // Bus idles with no strobe so nothing is taken before the first request.
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Write: strobe held for one edge, then the data lines show junk so a
  // design that samples late sees a wrong value.
  task automatic wr(input tcrf_addr_t a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read: data stand only in the cycle after the strobe edge.
  task automatic rd(input tcrf_addr_t a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// File: dv/tcrf_bench.sv
`timescale 1ns/1ps
// Compares two values and keeps the tallies.
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) \
    begin \
      failures++; \
      $display("FAIL %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tcrf_bench;
  import tcrf_pkg::*;
  logic        core_clk = 1'b0;  // 250 MHz clock.
  logic        arst_n = 1'b0;    // Held low for three edges.
  logic        conv_valid = 1'b0;
  tcrf_ch_t    conv_ch = 2'h0;
  logic        conv_bipolar = 1'b0;
  logic        conv_neg = 1'b0;
  tcrf_word_t  conv_count = 16'h0000;
  logic        conv_open = 1'b0;
  tcrf_addr_t  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  system_status_relay_bit;
  logic        irq;
  int          failures = 0;     // Mismatches seen.
  int          n_compared = 0;   // Comparisons made.
  int          cyc = 0;          // Cycle count for the hang guard.
  int          seed = 89045;     // Fixed seed for repeatable runs.
  logic [31:0] r;
  logic [15:0] rd_w;
  // Results read zero until their channel converts.
  logic [15:0] res_m [4] = '{default: 16'h0000};
  logic [3:0]  flag_m = 4'h0;    // Model of the burnout flags.
  logic [7:0]  stat_m = 8'h00;   // Model of the interrupt status.
  logic [7:0]  mask_m = 8'h00;   // Model of the interrupt mask.
  logic [2:0]  cfg = 3'h0;       // Model of the configuration.

  // Free-running clock, 4 ns period.
  always #2 core_clk = ~core_clk;

  tcrf_top uut (.core_clk(core_clk), .arst_n(arst_n),
    .conv_valid(conv_valid), .conv_ch(conv_ch),
    .conv_bipolar(conv_bipolar), .conv_neg(conv_neg),
    .conv_count(conv_count), .conv_open(conv_open),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .system_status_relay_bit(system_status_relay_bit), .irq(irq));

  tcrf_host host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // Prints the tallies and the verdict, then stops the run.
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The whole run needs about 375 cycles; over fifty times that means a hang.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // Expected word; burnout overrides the reading when detection is on.
  function automatic logic [15:0] expw(logic bip, logic neg,
                                       logic [15:0] c, logic op);
    int m;
    m = c[14:0];
    if (op && !cfg[0])
      return cfg[2] ? 16'h0000 : (bip ? 16'h7fff : 16'hffff);
    if (!bip)
      return c;
    if (!cfg[1])
      return {neg, c[14:0]};
    return neg ? 16'(-m) : 16'(m);
  endfunction

  // One conversion pulse, then the model takes the same step.
  task automatic conv(tcrf_ch_t ch, logic bip, logic neg, logic op,
                      logic [15:0] c);
    logic burn;
    burn = op & ~cfg[0];
    @(posedge core_clk);
    conv_valid <= 1'b1;
    conv_ch <= ch;
    conv_bipolar <= bip;
    conv_neg <= neg;
    conv_count <= c;
    conv_open <= op;
    @(posedge core_clk);
    conv_valid <= 1'b0;
    res_m[ch] = expw(bip, neg, c, op);
    if (burn && !flag_m[ch])
      stat_m[ch] = 1'b1;
    stat_m[4 + ch] = 1'b1;
    flag_m[ch] = burn;
    #1 `CHK("relay bits", flag_m, system_status_relay_bit)
  endtask

  // Reads every result pair and the flag and status registers.
  task automatic check_all();
    for (int ch = 0; ch < 4; ch++)
    begin
      host.rd(4'(2 * ch), rd_w);
      `CHK("result word", res_m[ch], rd_w)
      host.rd(4'(2 * ch + 1), rd_w);
      `CHK("second word", 16'h0000, rd_w)
    end
    host.rd(4'h9, rd_w);
    `CHK("burnout reg", {12'h000, flag_m}, rd_w)
    host.rd(4'ha, rd_w);
    `CHK("int status", {8'h00, stat_m}, rd_w)
  endtask

  // Main sequence: every configuration, random readings, then interrupts.
  initial
  begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    host.rd(4'h8, rd_w);
    `CHK("config reset", 16'h0000, rd_w)
    `CHK("relay reset", 4'h0, system_status_relay_bit)
    `CHK("irq reset", 1'b0, irq)
    for (int k = 0; k < 8; k++)
    begin
      cfg = k[2:0];
      host.wr(4'h8, {13'h0000, cfg});
      repeat (8)
      begin
        r = $random(seed);
        conv(r[7:6], r[8], r[9], r[0] & r[1],
             r[4] ? 16'($random(seed)) : {16{r[5]}});
      end
      check_all();
      mask_m = r[23:16];
      host.wr(4'hb, {8'h00, mask_m});
      host.rd(4'hb, rd_w);
      `CHK("int mask", {8'h00, mask_m}, rd_w)
      `CHK("irq level", |(stat_m & mask_m), irq)
      host.wr(4'ha, 16'h00ff);
      stat_m = 8'h00;
      host.rd(4'ha, rd_w);
      `CHK("status clear", 16'h0000, rd_w)
      `CHK("irq clear", 1'b0, irq)
      $display("test config %0d done", k);
    end
    host.rd(4'hc, rd_w);
    `CHK("unmapped read", 16'h0000, rd_w)
    conclude();
  end
endmodule
